/* File: logic/sspac_defs.svh */
// constants for the phy spread-spectrum and align control block
`ifndef SSPAC_DEFS_SVH
`define SSPAC_DEFS_SVH
// axi4-lite register byte offsets
`define SSPAC_REG_CTRL      8'h00
`define SSPAC_REG_STATUS    8'h04
`define SSPAC_REG_TOL       8'h08
`define SSPAC_REG_BUFMAX    8'h0C
// ctrl field positions and reset value
`define SSPAC_CTRL_EXP      0
`define SSPAC_CTRL_SATABAY  1
`define SSPAC_CTRL_SSCEN    2
`define SSPAC_CTRL_NOTROT   3
`define SSPAC_CTRL_RESET    32'h0000_0000
// tolerance buffer depths in dwords per link rate, and storage depth
`define SSPAC_BUF_6G        5'h0E
`define SSPAC_BUF_3G        5'h08
`define SSPAC_BUF_1G5       5'h04
`define SSPAC_BUF_DEPTH     16
// align character and code words, notify run and gap limits
`define SSPAC_K285          8'hBC
`define SSPAC_ALIGN0        32'h7B4A_4ABC
`define SSPAC_ALIGN1        32'h4ABC_BC4A
`define SSPAC_ALIGN2        32'h5555_BCBC
`define SSPAC_ALIGN3        32'hF2BC_BCBC
`define SSPAC_NOTIFY_MAXRUN 2'h3
`define SSPAC_NOTIFY_GAP    2'h3
// axi responses
`define SSPAC_RESP_OKAY     2'h0
`define SSPAC_RESP_SLVERR   2'h2
`endif

/* File: logic/sspac_pkg.sv */
// types for the phy spread-spectrum and align control block
package sspac_pkg;
	typedef enum logic [1:0] {SSC_NONE, SSC_DOWN, SSC_CENTER} sspac_ssc_t;
	typedef enum logic [1:0] {RATE_1G5, RATE_3G, RATE_6G} sspac_rate_t;
	typedef enum logic [1:0] {PH_OOB, PH_SPEEDNEG, PH_RUN} sspac_phase_t;
	typedef enum logic [1:0] {PART_UNKNOWN, PART_SAS, PART_SATA} sspac_part_t;
	// transmit request from link logic: want a deletable primitive
	typedef struct packed {
		logic        fill;
		logic        useNotify;
		logic [31:0] notifyWord;
	} sspac_txreq_t;
	// forwarded dword stream beat
	typedef struct packed {
		logic        valid;
		logic        deletable;
		logic [31:0] data;
	} sspac_beat_t;
endpackage

/* File: logic/sspac_ctrl.sv */
// spread-spectrum mode selection, tolerance buffer and align rotation
//
// Notes on behaviour
// - non-expander: no spreading if partner lacks it
// - non-expander with capable partner: none or down
// - expander: unmodulated if non-sata partner lacks spreading
// - expander, capable sas partner: none or center
// - expander, sata partner: none or down only
// - non-expander in sata bay may always down-spread
// - receivers tolerate none; sata-capable also sata down
// - tolerate center and down together or neither
// - center buffer: 14/8/4 dwords per rate
// - buffer holds dwords when receiver runs fast
// - buffer drains when receiver runs slow
// - transmit never timed from recovered receive clock
// - oob bursts use align version 0 only
// - speed negotiation sends align 0 and 1 only
// - after reset, aligns rotate 0,1,2,3
// - receiver accepts any align version any time
// - align recognised only after four characters
// - no notify during oob or speed negotiation
// - notify may take rotation slot or delay it
// - same notify max three dwords, then three others
`timescale 1ns/1ns
`include "sspac_defs.svh"
module sspac_ctrl (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	// axi4-lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// link initialisation status
	input  wire sspac_pkg::sspac_part_t partnerType,
	input  wire logic                 partnerSsc,
	input  wire sspac_pkg::sspac_phase_t phase,
	input  wire sspac_pkg::sspac_rate_t linkRate,
	// transmit side
	input  wire sspac_pkg::sspac_txreq_t txReq,
	output logic [31:0]               txWord,
	output logic                      txIsPrim,
	output sspac_pkg::sspac_ssc_t     txSscMode,
	// receive side: link clock and byte lanes from the phy
	input  wire logic                 rxLinkClk,
	input  wire logic [31:0]          rxData,
	input  wire logic [3:0]           rxIsK,
	output logic                      rxAlignSeen,
	// forwarded stream through the tolerance buffer
	input  wire sspac_pkg::sspac_beat_t fwdIn,
	input  wire logic                 fwdOutReady,
	output sspac_pkg::sspac_beat_t    fwdOut,
	output logic                      fwdOverflow
);

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	typedef struct packed {
		logic                     awReady;      // write address accept flag
		logic                     wReady;       // write data accept flag
		logic                     awHave;       // address held
		logic                     wHave;        // data held
		logic [7:0]               awAddr;       // held write address
		logic [31:0]              wData;        // held write data
		logic [3:0]               wStrb;        // held strobes
		logic                     bValid;       // write answer pending
		logic [1:0]               bResp;        // write answer code
		logic                     arReady;      // read address accept
		logic                     rValid;       // read answer pending
		logic [31:0]              rData;        // read answer data
		logic [1:0]               rResp;        // read answer code
		logic [31:0]              ctrl;         // control register
		sspac_pkg::sspac_ssc_t    sscMode;      // chosen transmit mode
		logic [1:0]               alignIdx;     // rotation position
		logic [31:0]              txWord;       // transmit dword
		logic                     txIsPrim;     // transmit is primitive
		logic [31:0]              lastNotify;   // last notify sent
		logic [1:0]               notifyRun;    // consecutive same notify
		logic [1:0]               otherRun;     // other dwords since
		logic [2:0]               lclkSync;     // link clock sync + edge
		logic [31:0]              rxS1;         // rx data first stage
		logic [31:0]              rxS2;         // rx data second stage
		logic [3:0]               kS1;          // rx k flags first stage
		logic [3:0]               kS2;          // rx k flags second stage
		logic                     alignSeen;    // align detected pulse
		logic [31:0]              alignCount;   // aligns seen
		logic [`SSPAC_BUF_DEPTH-1:0][32:0] tolMem; // tolerance storage
		logic [3:0]               wrPtr;        // buffer write index
		logic [3:0]               rdPtr;        // buffer read index
		logic [4:0]               level;        // dwords held
		logic [4:0]               levelMax;     // high water mark
		logic                     overflow;     // sticky overflow
		sspac_pkg::sspac_beat_t   outBeat;      // forwarded beat
	} sspac_state_t;

	sspac_state_t cur_q;    // registered state
	sspac_state_t nxt_d;    // next state

	//------------------------------------------------------------
	// functions
	//------------------------------------------------------------
	// align code for a rotation index
	function automatic logic [31:0] alignWord(input logic [1:0] idx);
		case (idx)
			2'h1:    return `SSPAC_ALIGN1;
			2'h2:    return `SSPAC_ALIGN2;
			2'h3:    return `SSPAC_ALIGN3;
			default: return `SSPAC_ALIGN0;
		endcase
	endfunction

	// tolerance depth for a link rate
	function automatic logic [4:0] bufLimit(input sspac_pkg::sspac_rate_t r);
		if (r == sspac_pkg::RATE_6G)
			return `SSPAC_BUF_6G;
		else if (r == sspac_pkg::RATE_3G)
			return `SSPAC_BUF_3G;
		return `SSPAC_BUF_1G5;
	endfunction

	// any of the four align codes
	function automatic logic isAlign(input logic [31:0] d, input logic [3:0] k);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 4; i++)
			if (d == alignWord(2'(i)))
				hit = 1'b1;
		// only the first byte is a control character
		return hit && (k == 4'h1);
	endfunction

	//------------------------------------------------------------
	// next-state logic
	//------------------------------------------------------------
	always_comb
	begin
		logic        wrFire;
		logic        rdFire;
		logic        isExp;
		logic        sataBay;
		logic        sscEn;
		logic        notRot;
		logic        push;
		logic        pop;
		logic        sendNotify;
		logic [31:0] rdVal;
		wrFire     = 1'b0;
		rdFire     = 1'b0;
		isExp      = 1'b0;
		sataBay    = 1'b0;
		sscEn      = 1'b0;
		notRot     = 1'b0;
		push       = 1'b0;
		pop        = 1'b0;
		sendNotify = 1'b0;
		rdVal      = 32'h0000_0000;
		nxt_d      = cur_q;

		// write channel: address and data in any order
		if (s_axi_awvalid && cur_q.awReady)
		begin
			nxt_d.awHave = 1'b1;
			nxt_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && cur_q.wReady)
		begin
			nxt_d.wHave = 1'b1;
			nxt_d.wData = s_axi_wdata;
			nxt_d.wStrb = s_axi_wstrb;
		end
		nxt_d.awReady = !nxt_d.awHave && !cur_q.bValid;
		nxt_d.wReady  = !nxt_d.wHave && !cur_q.bValid;
		wrFire = cur_q.awHave && cur_q.wHave && !cur_q.bValid;
		if (wrFire)
		begin
			nxt_d.awHave  = 1'b0;
			nxt_d.wHave   = 1'b0;
			nxt_d.awReady = 1'b0;
			nxt_d.wReady  = 1'b0;
			nxt_d.bValid  = 1'b1;
			nxt_d.bResp   = `SSPAC_RESP_OKAY;
			if (cur_q.awAddr == `SSPAC_REG_CTRL)
			begin
				for (int b = 0; b < 4; b++)
					if (cur_q.wStrb[b])
						nxt_d.ctrl[b*8 +: 8] = cur_q.wData[b*8 +: 8];
			end
			else if (cur_q.awAddr == `SSPAC_REG_BUFMAX)
				nxt_d.levelMax = 5'h00; // write clears high water
			else if (cur_q.awAddr == `SSPAC_REG_STATUS)
				nxt_d.overflow = 1'b0; // write clears overflow
			else if (cur_q.awAddr != `SSPAC_REG_TOL)
				nxt_d.bResp = `SSPAC_RESP_SLVERR;
		end
		else if (cur_q.bValid && s_axi_bready)
		begin
			nxt_d.bValid  = 1'b0;
			nxt_d.awReady = 1'b1;
			nxt_d.wReady  = 1'b1;
		end
		// read channel
		rdFire = s_axi_arvalid && cur_q.arReady;
		if (rdFire)
		begin
			nxt_d.arReady = 1'b0;
			nxt_d.rValid  = 1'b1;
			nxt_d.rResp   = `SSPAC_RESP_OKAY;
			if (s_axi_araddr == `SSPAC_REG_CTRL)
				rdVal = cur_q.ctrl;
			else if (s_axi_araddr == `SSPAC_REG_STATUS)
				rdVal = {cur_q.alignCount[23:0], 3'h0, cur_q.overflow,
					2'(cur_q.sscMode), 2'(phase)};
			else if (s_axi_araddr == `SSPAC_REG_TOL)
				// bit0 none, bit1 down, bit2 center, bit3 sata down
				rdVal = {28'h0000000, 4'hF};
			else if (s_axi_araddr == `SSPAC_REG_BUFMAX)
				rdVal = {22'h000000, cur_q.level, cur_q.levelMax};
			else
				nxt_d.rResp = `SSPAC_RESP_SLVERR;
			nxt_d.rData = rdVal;
		end
		else if (cur_q.rValid && s_axi_rready)
		begin
			nxt_d.rValid  = 1'b0;
			nxt_d.arReady = 1'b1;
		end
		// transmit modulation selection
		isExp   = cur_q.ctrl[`SSPAC_CTRL_EXP];
		sataBay = cur_q.ctrl[`SSPAC_CTRL_SATABAY];
		sscEn   = cur_q.ctrl[`SSPAC_CTRL_SSCEN];
		notRot  = cur_q.ctrl[`SSPAC_CTRL_NOTROT];
		nxt_d.sscMode = sspac_pkg::SSC_NONE;
		if (!isExp && sataBay && sscEn)
			nxt_d.sscMode = sspac_pkg::SSC_DOWN;
		else if (partnerType == sspac_pkg::PART_UNKNOWN)
			nxt_d.sscMode = sspac_pkg::SSC_NONE;
		else if (!isExp)
		begin
			if (partnerSsc && sscEn)
				nxt_d.sscMode = sspac_pkg::SSC_DOWN;
		end
		else if (partnerType == sspac_pkg::PART_SATA)
		begin
			if (sscEn)
				nxt_d.sscMode = sspac_pkg::SSC_DOWN;
		end
		else if (partnerSsc && sscEn)
			nxt_d.sscMode = sspac_pkg::SSC_CENTER;
		// transmit primitive generation; transmit logic lives on sys_clk only
		nxt_d.txIsPrim = txReq.fill;
		nxt_d.txWord   = txReq.notifyWord;
		case (phase)
			sspac_pkg::PH_OOB:
			begin
				nxt_d.txWord   = `SSPAC_ALIGN0;
				nxt_d.alignIdx = 2'h0;
			end
			sspac_pkg::PH_SPEEDNEG:
			begin
				if (txReq.fill)
				begin
					nxt_d.txWord   = alignWord({1'b0, cur_q.alignIdx[0]});
					nxt_d.alignIdx = {1'b0, ~cur_q.alignIdx[0]};
				end
			end
			default:
			begin
				if (txReq.fill)
				begin
					sendNotify = txReq.useNotify &&
						!(txReq.notifyWord == cur_q.lastNotify &&
						  cur_q.notifyRun == `SSPAC_NOTIFY_MAXRUN &&
						  cur_q.otherRun != `SSPAC_NOTIFY_GAP);
					if (sendNotify)
					begin
						nxt_d.txWord = txReq.notifyWord;
						if (!notRot)
							nxt_d.alignIdx = cur_q.alignIdx + 2'h1;
					end
					else
					begin
						nxt_d.txWord   = alignWord(cur_q.alignIdx);
						nxt_d.alignIdx = cur_q.alignIdx + 2'h1;
					end
				end
			end
		endcase
		// notify run bookkeeping: three others reset the run
		if (sendNotify && phase == sspac_pkg::PH_RUN)
		begin
			nxt_d.otherRun = 2'h0;
			if (txReq.notifyWord == cur_q.lastNotify &&
				cur_q.otherRun != `SSPAC_NOTIFY_GAP)
				nxt_d.notifyRun = cur_q.notifyRun + 2'h1;
			else
				nxt_d.notifyRun = 2'h1;
			nxt_d.lastNotify = txReq.notifyWord;
		end
		else if (cur_q.otherRun != `SSPAC_NOTIFY_GAP)
			nxt_d.otherRun = cur_q.otherRun + 2'h1;
		else
			nxt_d.notifyRun = 2'h0;
		// receive: sync link clock and data, sample on link clock rise
		nxt_d.lclkSync  = {cur_q.lclkSync[1:0], rxLinkClk};
		nxt_d.rxS1      = rxData;
		nxt_d.rxS2      = cur_q.rxS1;
		nxt_d.kS1       = rxIsK;
		nxt_d.kS2       = cur_q.kS1;
		nxt_d.alignSeen = 1'b0;
		if (cur_q.lclkSync[1] && !cur_q.lclkSync[2])
		begin
			// whole dword compared, any version accepted
			if (isAlign(cur_q.rxS2, cur_q.kS2))
			begin
				nxt_d.alignSeen  = 1'b1;
				nxt_d.alignCount = cur_q.alignCount + 32'h1;
			end
		end
		// center-spreading tolerance buffer
		pop  = (cur_q.level != 5'h00) && (!cur_q.outBeat.valid || fwdOutReady);
		push = fwdIn.valid && !(fwdIn.deletable && cur_q.level != 5'h00);
		if (pop)
		begin
			nxt_d.outBeat.valid     = 1'b1;
			nxt_d.outBeat.deletable = cur_q.tolMem[cur_q.rdPtr][32];
			nxt_d.outBeat.data      = cur_q.tolMem[cur_q.rdPtr][31:0];
			nxt_d.rdPtr = cur_q.rdPtr + 4'h1;
		end
		else if (fwdOutReady)
			nxt_d.outBeat.valid = 1'b0;
		if (push)
		begin
			if (cur_q.level - (pop ? 5'h01 : 5'h00) < bufLimit(linkRate))
			begin
				nxt_d.tolMem[cur_q.wrPtr] = {fwdIn.deletable, fwdIn.data};
				nxt_d.wrPtr = cur_q.wrPtr + 4'h1;
			end
			else
			begin
				push = 1'b0;
				nxt_d.overflow = 1'b1;
			end
		end
		nxt_d.level = cur_q.level + (push ? 5'h01 : 5'h00) - (pop ? 5'h01 : 5'h00);
		if (nxt_d.level > nxt_d.levelMax) // a new high beats a clear
			nxt_d.levelMax = nxt_d.level;
		if (!rst_b)
		begin
			nxt_d         = '0;
			nxt_d.ctrl    = `SSPAC_CTRL_RESET;
			nxt_d.awReady = 1'b1;
			nxt_d.wReady  = 1'b1;
			nxt_d.arReady = 1'b1;
		end
	end

	//------------------------------------------------------------
	// state register
	//------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		cur_q <= nxt_d;
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	assign s_axi_awready = cur_q.awReady;
	assign s_axi_wready  = cur_q.wReady;
	assign s_axi_bvalid  = cur_q.bValid;
	assign s_axi_bresp   = cur_q.bResp;
	assign s_axi_arready = cur_q.arReady;
	assign s_axi_rvalid  = cur_q.rValid;
	assign s_axi_rdata   = cur_q.rData;
	assign s_axi_rresp   = cur_q.rResp;
	assign txWord        = cur_q.txWord;
	assign txIsPrim      = cur_q.txIsPrim;
	assign txSscMode     = cur_q.sscMode;
	assign rxAlignSeen   = cur_q.alignSeen;
	assign fwdOut        = cur_q.outBeat;
	assign fwdOverflow   = cur_q.overflow;

endmodule

/* File: verification/sspac_ctrl_sva.sv */
// port assertions for the spread-spectrum and align control block
`timescale 1ns/1ns
`include "sspac_defs.svh"
module sspac_ctrl_sva (
	input wire logic                    sys_clk,
	input wire logic                    rst_b,
	input wire sspac_pkg::sspac_part_t  partnerType,
	input wire logic                    partnerSsc,
	input wire sspac_pkg::sspac_phase_t phase,
	input wire sspac_pkg::sspac_txreq_t txReq,
	input wire logic [31:0]             txWord,
	input wire logic                    txIsPrim,
	input wire sspac_pkg::sspac_ssc_t   txSscMode,
	input wire logic                    rxAlignSeen,
	input wire sspac_pkg::sspac_beat_t  fwdOut,
	input wire logic                    fwdOutReady
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// -----------------------------------------
	// helpers
	// -----------------------------------------
	// true for any of the four align words
	function automatic logic isAl(input logic [31:0] a);
		return a inside {`SSPAC_ALIGN0, `SSPAC_ALIGN1, `SSPAC_ALIGN2, `SSPAC_ALIGN3};
	endfunction
	// successor in the align rotation
	function automatic logic [31:0] nxAl(input logic [31:0] a);
		case (a)
			`SSPAC_ALIGN0: return `SSPAC_ALIGN1;
			`SSPAC_ALIGN1: return `SSPAC_ALIGN2;
			`SSPAC_ALIGN2: return `SSPAC_ALIGN3;
			default: return `SSPAC_ALIGN0;
		endcase
	endfunction
	// a notify on the line, then the same notify again
	sequence sNotify;
		txIsPrim && !isAl(txWord);
	endsequence
	sequence sRepeat;
		txIsPrim && !isAl(txWord) && $stable(txWord);
	endsequence
	sequence sRun3;
		sNotify ##1 sRepeat ##1 sRepeat;
	endsequence
	// run-phase fill right after a run-phase align
	sequence sRunFill;
		$past(phase) == sspac_pkg::PH_RUN && phase == sspac_pkg::PH_RUN
			&& txReq.fill && !txReq.useNotify && txIsPrim && isAl(txWord);
	endsequence
	// -----------------------------------------
	// assertions
	// -----------------------------------------
	a_oob_align0: assert property (phase == sspac_pkg::PH_OOB && txReq.fill |=>
		txWord == `SSPAC_ALIGN0) else $error("oob word not align zero");
	a_negot_align01: assert property (phase == sspac_pkg::PH_SPEEDNEG && txReq.fill |=>
		txWord inside {`SSPAC_ALIGN0, `SSPAC_ALIGN1}) else $error("bad negotiation word");
	a_no_early_notify: assert property (phase != sspac_pkg::PH_RUN && txReq.fill
		&& txReq.useNotify |=> isAl(txWord)) else $error("notify before run phase");
	a_align_rotate: assert property (sRunFill |=> txWord == nxAl($past(txWord)))
		else $error("align rotation broken");
	a_notify_run: assert property (sRun3 |=> !(txIsPrim && $stable(txWord)))
		else $error("notify repeated four times");
	a_center_sas_only: assert property ((!partnerSsc || partnerType != sspac_pkg::PART_SAS)[*3]
		|-> txSscMode != sspac_pkg::SSC_CENTER) else $error("center spreading not allowed");
	a_fwd_hold: assert property (fwdOut.valid && !fwdOutReady |=> $stable(fwdOut))
		else $error("forwarded beat dropped while stalled");
	a_rx_pulse: assert property (rxAlignSeen |=> !rxAlignSeen [*4])
		else $error("align seen more than once per link dword");
endmodule
bind sspac_ctrl sspac_ctrl_sva sspac_ctrl_sva_i (.*);

/* File: verification/sspac_phy_model.sv */
// attached phy: link clock and receive dwords
`timescale 1ns/1ns
module sspac_phy_model (
	input  wire logic        mdlOn,
	input  wire logic [31:0] mdlWord,
	input  wire logic [3:0]  mdlK,
	output logic             rxLinkClk,
	output logic [31:0]      rxData,
	output logic [3:0]       rxIsK
);
	// clock ticks every half link period, off the system clock grid
	initial
	begin
		rxLinkClk = 1'h0;
		rxData = 32'h0000_0000;
		rxIsK = 4'h0;
		#7;
		forever
		begin
			#80;
			// link clock stands low outside a frame
			rxLinkClk = mdlOn ? ~rxLinkClk : 1'h0;
			// new dword on falling edge; idle data inverts each tick, no control flags
			if (!rxLinkClk)
			begin
				rxData = mdlOn ? mdlWord : ~rxData;
				rxIsK = mdlOn ? mdlK : 4'h0;
			end
		end
	end
endmodule

/* File: verification/test_sas_phy_ssc_align_control.sv */
// self-checking bench for the spread-spectrum and align control block
`timescale 1ns/1ns
`include "sspac_defs.svh"
module test_sas_phy_ssc_align_control;
	logic sys_clk = 1'h0, rst_b = 1'h0, partnerSsc = 1'h0, fwdOutReady = 1'h0, mdlOn = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, mdlWord = 32'h0, s_axi_rdata, txWord, rxData, rdv;
	logic [3:0]  s_axi_wstrb = 4'hF, mdlK = 4'h0, rxIsK;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        txIsPrim, rxAlignSeen, fwdOverflow, rxLinkClk;
	sspac_pkg::sspac_part_t  partnerType = sspac_pkg::PART_UNKNOWN;
	sspac_pkg::sspac_phase_t phase = sspac_pkg::PH_OOB;
	sspac_pkg::sspac_rate_t  linkRate = sspac_pkg::RATE_1G5;
	sspac_pkg::sspac_txreq_t txReq = '0;
	sspac_pkg::sspac_ssc_t   txSscMode;
	sspac_pkg::sspac_beat_t  fwdIn = '0, fwdOut;
	logic [31:0] w [12];                 // captured transmit words
	int fail_count = 0, samples_checked = 0;
	localparam logic [31:0] NOTW = 32'h3C5A_96E1;  // a notify word
	// ctrl, partner type, partner ssc, expected mode
	localparam logic [15:0] SSC_TAB [8] = '{16'h4111, 16'h4100, 16'h4010, 16'h6001,
		16'h5112, 16'h5100, 16'h5211, 16'h1110};
	// control flags and dword sent by the attached phy
	localparam logic [35:0] RX_TAB [6] = '{{4'h1, `SSPAC_ALIGN3}, {4'h1, `SSPAC_ALIGN1},
		{4'h1, `SSPAC_ALIGN0}, {4'h1, `SSPAC_ALIGN2}, 36'h1_0000_00BC, {4'hF, `SSPAC_ALIGN0}};
	always #10 sys_clk = ~sys_clk;
	sspac_ctrl sspac_ctrl_i (.*);
	sspac_phy_model sspac_phy_model_i (.*);
	// -----------------------------------------
	// checking and closing
	// -----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task hang;
		fail_count++;
		$display("mismatch at %0t: wait timed out", $time);
		report_and_stop;
	endtask
	// successor in the align rotation, unknown for anything else
	function automatic logic [31:0] nxt(input logic [31:0] a);
		case (a)
			`SSPAC_ALIGN0: return `SSPAC_ALIGN1;
			`SSPAC_ALIGN1: return `SSPAC_ALIGN2;
			`SSPAC_ALIGN2: return `SSPAC_ALIGN3;
			`SSPAC_ALIGN3: return `SSPAC_ALIGN0;
			default: return 32'hXXXX_XXXX;
		endcase
	endfunction
	// -----------------------------------------
	// axi4-lite master
	// -----------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (++n > 50) hang;
		end
		while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		int n;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (++n > 50) hang;
		end
		while (!s_axi_rvalid);
		{rdv, rsp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'h0;
	endtask
	// -----------------------------------------
	// scenarios
	// -----------------------------------------
	// reset value, tolerance set, unmapped place
	task t_regs;
		rd(`SSPAC_REG_CTRL);
		chk(rdv, `SSPAC_CTRL_RESET);
		rd(`SSPAC_REG_TOL);
		chk(rdv, 32'h0000_000F);
		rd(8'h40);
		chk(32'(rsp), 32'(`SSPAC_RESP_SLVERR));
		wr(8'h40, 32'h0000_0000);
		chk(32'(rsp), 32'(`SSPAC_RESP_SLVERR));
		wr(`SSPAC_REG_CTRL, `SSPAC_CTRL_RESET);
		chk(32'(rsp), 32'(`SSPAC_RESP_OKAY));
	endtask
	// transmit modulation for each role and partner
	task t_ssc;
		for (int i = 0; i < 8; i++)
		begin
			wr(`SSPAC_REG_CTRL, {28'h0, SSC_TAB[i][15:12]});
			partnerType <= sspac_pkg::sspac_part_t'(SSC_TAB[i][9:8]);
			partnerSsc <= SSC_TAB[i][4];
			repeat (4) @(posedge sys_clk);
			chk(32'(txSscMode), 32'(SSC_TAB[i][1:0]));
			rd(`SSPAC_REG_STATUS);
			chk(32'(rdv[3:2]), 32'(SSC_TAB[i][1:0]));
		end
	endtask
	// capture twelve words; notify asked from sample sw on
	task grab(input int sw);
		for (int i = 0; i < 12; i++)
		begin
			@(posedge sys_clk);
			w[i] = txWord;
			if (i == sw) txReq.useNotify <= 1'h1;
		end
	endtask
	// oob and negotiation words, notify asked but refused
	task t_early;
		txReq <= '{1'h1, 1'h1, NOTW};
		grab(99);
		for (int i = 3; i < 12; i++) chk(w[i], `SSPAC_ALIGN0);
		phase <= sspac_pkg::PH_SPEEDNEG;
		grab(99);
		for (int i = 3; i < 11; i++) chk(w[i] ^ w[i+1], `SSPAC_ALIGN0 ^ `SSPAC_ALIGN1);
	endtask
	// rotation, notify run limit, slot or postpone
	task t_rot(input logic post);
		wr(`SSPAC_REG_CTRL, {28'h0, post, 3'h0});
		txReq <= '{1'h1, 1'h0, NOTW};
		phase <= sspac_pkg::PH_RUN;
		grab(5);
		for (int i = 3; i < 6; i++) chk(w[i+1], nxt(w[i]));
		for (int i = 7; i < 10; i++) chk(w[i], NOTW);
		chk(w[10], post ? nxt(w[6]) : w[6]);
		chk(w[11], nxt(w[10]));
		// after three other dwords the same notify is allowed again
		grab(99);
		for (int i = 1; i < 4; i++) chk(w[i], NOTW);
		chk(w[4], post ? nxt(w[0]) : w[0]);
		txReq <= '0;
	endtask
	// attached phy sends one dword repeatedly
	task t_rx;
		int seen;
		for (int i = 0; i < 6; i++)
		begin
			seen = 0;
			{mdlK, mdlWord} <= RX_TAB[i];
			mdlOn <= 1'h1;
			repeat (40)
			begin
				@(posedge sys_clk);
				if (rxAlignSeen) seen++;
			end
			mdlOn <= 1'h0;
			repeat (20) @(posedge sys_clk);
			chk(32'(seen > 0), 32'(i < 4));
		end
	endtask
	task push(input logic [31:0] d, input logic del);
		@(posedge sys_clk);
		fwdIn <= '{1'h1, del, d};
		@(posedge sys_clk);
		fwdIn <= '0;
	endtask
	// drain a stalled stream; first beats must match exp
	task drain(input logic [31:0] e0, input logic [31:0] e1, output int got);
		got = 0;
		fwdOutReady <= 1'h1;
		repeat (60)
		begin
			@(posedge sys_clk);
			if (fwdOut.valid && fwdOutReady && got < 2) chk(fwdOut.data, got ? e1 : e0);
			if (fwdOut.valid && fwdOutReady) got++;
		end
		chk(32'(fwdOut.valid), 32'h0);
		fwdOutReady <= 1'h0;
	endtask
	// tolerance buffer depth per rate
	task t_buf(input sspac_pkg::sspac_rate_t r, input int lim);
		int got;
		linkRate <= r;
		for (int n = 0; n < lim; n++) push(32'(n), 1'h0);
		repeat (3) @(posedge sys_clk);
		chk(32'(fwdOverflow), 32'h0);
		push(32'h0000_00AA, 1'h0);
		push(32'h0000_00AB, 1'h0);
		repeat (3) @(posedge sys_clk);
		chk(32'(fwdOverflow), 32'h1);
		drain(32'h0, 32'h1, got);
		chk(32'(got >= lim), 32'h1);
		rd(`SSPAC_REG_BUFMAX);
		chk(rdv, 32'(lim));
		wr(`SSPAC_REG_STATUS, 32'h0000_0010);
		rd(`SSPAC_REG_STATUS);
		chk(32'(rdv[4]), 32'h0);
	endtask
	// deletable beat dropped while the buffer holds data
	task t_del;
		int got;
		push(32'h0000_0005, 1'h0);
		push(32'h0000_0008, 1'h0);
		push(32'h0000_0006, 1'h1);
		push(32'h0000_0007, 1'h0);
		drain(32'h5, 32'h8, got);
		chk(32'(got), 32'h3);
	endtask
	// -----------------------------------------
	// main sequence
	// -----------------------------------------
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'h1;
		t_regs;
		t_ssc;
		t_early;
		t_rot(1'h0);
		t_rot(1'h1);
		t_rx;
		t_buf(sspac_pkg::RATE_1G5, 4);
		t_buf(sspac_pkg::RATE_3G, 8);
		t_buf(sspac_pkg::RATE_6G, 14);
		t_del;
		report_and_stop;
	end
endmodule
